// >>> incr_alu.v
// Purpose: Increment arithmetic with status flag generation
// Assumes: Pure combinational, same clock domain as caller
// Notes:   Flags follow an add of one with no carry in
`timescale 1ns/100ps
module incr_alu (
   input  wire [7:0] val_i,
   output wire [7:0] sum_o,
   output wire [4:0] flags_o
);
   wire [8:0] full;
   wire [4:0] low;

   assign full  = {1'b0, val_i} + 9'h001;
   assign low   = {1'b0, val_i[3:0]} + 5'h01;
   assign sum_o = full[7:0];
   // Order: negative, overflow, zero, digit carry, carry
   assign flags_o = {full[7], (~val_i[7] & full[7]),
                     (full[7:0] == 8'h00), low[4], full[8]};
endmodule // incr_alu

// >>> incr_jump_checker.sv
// Purpose: Port assertions for incr_jump_exec
// Assumes: One clock, asynchronous active-high reset
// Notes:   Results appear at phase 0 after the decode cycle
`timescale 1ns/100ps
module incr_jump_checker (
   input wire        clk_i,
   input wire        rst_i,
   input wire [15:0] instr_i,
   input wire [7:0]  rd_data_i,
   input wire [11:0] mem_addr_o,
   input wire        mem_rd_o,
   input wire        mem_wr_o,
   input wire [7:0]  wr_data_o,
   input wire [7:0]  wreg_o,
   input wire [4:0]  status_o,
   input wire [1:0]  phase_o,
   input wire        pc_load_o,
   input wire [20:0] pc_target_o,
   input wire        flush_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_rd; mem_rd_o |-> phase_o == 2'h1; endproperty
   a_rd: assert property (p_rd) else $error("read off phase");
   property p_wr; mem_wr_o |-> phase_o == 2'h0 && $past(instr_i[9], 4);
   endproperty
   a_wr: assert property (p_wr) else $error("bad write");
   property p_wd; mem_wr_o |-> wr_data_o == $past(rd_data_i, 3) + 8'h01;
   endproperty
   a_wd: assert property (p_wd) else $error("bad sum");
   property p_st; $changed(status_o) |-> $past(instr_i[15:10], 4) == 6'h0A;
   endproperty
   a_st: assert property (p_st) else $error("stray flags");
   property p_wg; $changed(wreg_o) |-> !$past(instr_i[9], 4); endproperty
   a_wg: assert property (p_wg) else $error("stray wreg");
   property p_pc; pc_load_o |-> flush_o && !pc_target_o[0]; endproperty
   a_pc: assert property (p_pc) else $error("bad jump");
   property p_fl; flush_o |-> phase_o == 2'h0 ##1 !flush_o; endproperty
   a_fl: assert property (p_fl) else $error("bad flush");
   property p_ad; mem_rd_o |=> $stable(mem_addr_o); endproperty
   a_ad: assert property (p_ad) else $error("addr moved");
endmodule // incr_jump_checker

// >>> incr_jump_defs.vh
// Purpose: Constants for the increment and long jump execution block
// Assumes: 16-bit instruction words, 8-bit data, 12-bit data addresses
// Notes:   Opcode fields are matched on the upper bits of the word
`ifndef INCR_JUMP_DEFS_VH
`define INCR_JUMP_DEFS_VH

`define OPC6_INC_FILE    6'h0A
`define OPC6_INC_SKZ     6'h0F
`define OPC6_INC_SKNZ    6'h12
`define OPC8_JUMP1       8'hEF
`define OPC4_JUMP2       4'hF
`define IDX_LIMIT        8'h5F
`define ACC_SPLIT        8'h60
`define ACC_HIGH_BANK    4'hF
`define ST_C             0
`define ST_DIG           1
`define ST_Z             2
`define ST_OVF           3
`define ST_N             4
`define PH_Q1            2'h0
`define PH_Q2            2'h1
`define PH_Q3            2'h2
`define PH_Q4            2'h3
`define STATUS_RST       5'h00
`define WREG_RST         8'h00

`endif

// >>> incr_jump_exec.v
// Purpose: Executes increment_file, increment_skip variants, long_jump
// Assumes: Q phases counted locally; data memory answers within a phase
// Notes:   One instruction word per cycle, presented for the whole cycle
//          Jump word two follows word one, then one discarded cycle
//
// Contract
// - Increment takes 8-bit file address plus one-bit destination and bank.
// - Increment recognised by opcode 0010 10, then d, a, file address.
// - Increment adds one to the file value, wrapping FFh to 00h.
// - Destination bit 0 writes working register, 1 writes file back.
// - Increment updates carry, digit carry, negative, overflow and zero.
// - Bank operand 0 selects the fixed access bank.
// - Bank operand 1 takes upper address from bank_select_register.
// - Extended set, bank 0, address up to 95 uses indexed offset.
// - long_jump loads its 20-bit target into PC bits 20 to 1.
// - long_jump always takes two cycles, second is a no-operation; here word two loads the PC and a third, discarded cycle follows.
// - Skip-if-nonzero variant discards next instruction on nonzero result.
`timescale 1ns/100ps
`include "incr_jump_defs.vh"
module incr_jump_exec (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire [15:0] instr_i,
   input  wire        ext_set_i,
   input  wire [3:0]  bank_select_register_i,
   input  wire [11:0] fsr2_i,
   input  wire [7:0]  rd_data_i,
   output reg  [11:0] mem_addr_o,
   output reg         mem_rd_o,
   output reg         mem_wr_o,
   output reg  [7:0]  wr_data_o,
   output reg  [7:0]  wreg_o,
   output reg  [4:0]  status_o,
   output reg  [1:0]  phase_o,
   output reg         pc_load_o,
   output reg  [20:0] pc_target_o,
   output reg         flush_o,
   output reg         busy_o
);
   localparam S_RUN   = 2'd0;
   localparam S_JUMP2 = 2'd1;
   localparam S_NOP   = 2'd2;

   // Kind of instruction latched at decode
   localparam K_NONE  = 3'd0;
   localparam K_INC   = 3'd1;
   localparam K_INC_Z = 3'd2;
   localparam K_INC_N = 3'd3;
   localparam K_JUMP  = 3'd4;

   reg  [1:0]  state_r;
   reg  [1:0]  state_nxt;
   reg  [7:0]  k_low_r;
   reg  [7:0]  op_val_r;
   reg  [2:0]  kind_r;
   reg         dest_r;
   wire [7:0]  sum;
   wire [4:0]  flags;

   // Addressing for byte operands
   function [11:0] f_addr;
      input [7:0]  f;
      input        a;
      input        ext;
      input [3:0]  bank;
      input [11:0] base;
      begin
         if (a)
            f_addr = {bank, f};
         else if (ext && f <= `IDX_LIMIT)
            // Wraps inside the 4K data space, as the index register does
            f_addr = base + {4'h0, f};
         else if (f < `ACC_SPLIT)
            f_addr = {4'h0, f};
         else
            f_addr = {`ACC_HIGH_BANK, f};
      end
   endfunction

   // Opcode to kind; anything else decodes as nothing
   function [2:0] f_kind;
      input [15:0] w;
      begin
         case (w[15:10])
            `OPC6_INC_FILE: f_kind = K_INC;
            `OPC6_INC_SKZ:  f_kind = K_INC_Z;
            `OPC6_INC_SKNZ: f_kind = K_INC_N;
            default: begin
               if (w[15:8] == `OPC8_JUMP1)
                  f_kind = K_JUMP;
               else
                  f_kind = K_NONE;
            end
         endcase
      end
   endfunction

   // Skip test of the two increment-and-skip kinds
   function f_skip;
      input [2:0] k;
      input [7:0] s;
      begin
         f_skip = (k == K_INC_Z && s == 8'h00) ||
                  (k == K_INC_N && s != 8'h00);
      end
   endfunction

   // Increment kinds read a file register and write a destination
   function f_is_inc;
      input [2:0] k;
      begin
         f_is_inc = (k == K_INC) || (k == K_INC_Z) || (k == K_INC_N);
      end
   endfunction

   wire [2:0] kind_dec  = f_kind(instr_i);
   wire       jump_tail = (instr_i[15:12] == `OPC4_JUMP2);
   wire       skip_now  = f_skip(kind_r, sum);

   incr_alu u_alu (
      .val_i   (op_val_r),
      .sum_o   (sum),
      .flags_o (flags)
   );

   // Jump: word one in S_RUN, word two in S_JUMP2, then S_NOP
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_RUN: begin
            if (phase_o == `PH_Q4 && kind_r == K_JUMP)
               state_nxt = S_JUMP2;
            else if (phase_o == `PH_Q4 && skip_now)
               state_nxt = S_NOP;
         end
         S_JUMP2: begin
            // Malformed word two loads nothing, so nothing to discard
            if (phase_o == `PH_Q4)
               state_nxt = jump_tail ? S_NOP : S_RUN;
         end
         S_NOP: begin
            if (phase_o == `PH_Q4)
               state_nxt = S_RUN;
         end
         default: state_nxt = S_RUN;
      endcase
   end

   // Phase runs free; the Q1 edge is the one where phase_o is 0
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r     <= S_RUN;
         phase_o     <= `PH_Q1;
         k_low_r     <= 8'h00;
         op_val_r    <= 8'h00;
         kind_r      <= 3'd0;
         dest_r      <= 1'b0;
         mem_addr_o  <= 12'h000;
         mem_rd_o    <= 1'b0;
         mem_wr_o    <= 1'b0;
         wr_data_o   <= 8'h00;
         wreg_o      <= `WREG_RST;
         status_o    <= `STATUS_RST;
         pc_load_o   <= 1'b0;
         pc_target_o <= 21'h00_0000;
         flush_o     <= 1'b0;
         busy_o      <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         phase_o   <= phase_o + 2'd1;
         mem_rd_o  <= 1'b0;
         mem_wr_o  <= 1'b0;
         pc_load_o <= 1'b0;
         flush_o   <= 1'b0;
         busy_o    <= (state_nxt != S_RUN);
         case (phase_o)
            `PH_Q1: begin
               // Discarded slots decode as nothing; word two keeps the jump
               if (state_r == S_RUN)
                  kind_r <= kind_dec;
               else if (state_r != S_JUMP2)
                  kind_r <= K_NONE;
               if (state_r == S_RUN) begin
                  dest_r <= instr_i[9];
                  if (f_is_inc(kind_dec)) begin
                     mem_addr_o <= f_addr(instr_i[7:0], instr_i[8],
                        ext_set_i, bank_select_register_i, fsr2_i);
                     mem_rd_o   <= 1'b1;
                  end
                  if (kind_dec == K_JUMP)
                     k_low_r <= instr_i[7:0];
               end
            end
            `PH_Q2: begin
               if (f_is_inc(kind_r))
                  op_val_r <= rd_data_i;
            end
            `PH_Q3: begin
               // Increment settles in the ALU from op_val_r
            end
            default: begin
               // Target loads only with word two on instr_i
               if (state_r == S_JUMP2 && kind_r == K_JUMP && jump_tail) begin
                  pc_target_o <= {instr_i[11:0], k_low_r, 1'b0};
                  pc_load_o   <= 1'b1;
                  flush_o     <= 1'b1;
               end
               if (f_is_inc(kind_r)) begin
                  if (dest_r) begin
                     mem_wr_o  <= 1'b1;
                     wr_data_o <= sum;
                  end else begin
                     wreg_o <= sum;
                  end
                  if (kind_r == K_INC)
                     status_o <= flags;
                  if (skip_now)
                     flush_o <= 1'b1;
               end
            end
         endcase
      end
   end
endmodule // incr_jump_exec

// >>> increment_and_jump_execution_test.sv
// Purpose: Directed bench for incr_jump_exec
// Assumes: One instruction word per four clocks
// Notes:   Each op returns at phase 0 with results visible
`timescale 1ns/100ps
module increment_and_jump_execution_test;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg  [15:0] instr_i = 16'h0000;
   reg         ext = 1'b0;
   reg  [3:0]  bank_sel = 4'h0;
   reg  [11:0] fsr2 = 12'h0200;
   reg  [7:0]  rd_data_i = 8'h00;
   wire [11:0] mem_addr_o;
   wire        mem_rd_o, mem_wr_o, pc_load_o, flush_o, busy_o;
   wire [7:0]  wr_data_o, wreg_o;
   wire [4:0]  status_o;
   wire [1:0]  phase_o;
   wire [20:0] pc_target_o;
   integer     mismatches = 0;
   integer     total_checks = 0;
   incr_jump_exec dut_u (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i),
      .ext_set_i(ext), .bank_select_register_i(bank_sel), .fsr2_i(fsr2),
      .rd_data_i(rd_data_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
      .mem_wr_o(mem_wr_o), .wr_data_o(wr_data_o), .wreg_o(wreg_o),
      .status_o(status_o), .phase_o(phase_o), .pc_load_o(pc_load_o),
      .pc_target_o(pc_target_o), .flush_o(flush_o), .busy_o(busy_o));
   initial forever #25 clk_i = ~clk_i;
   task complete_run; begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end endtask
   task chk(input [63:0] nm, input [31:0] s, input [31:0] e); begin
      total_checks = total_checks + 1;
      if (s !== e) begin
         mismatches = mismatches + 1;
         $display("MISMATCH %0s exp %h seen %h", nm, e, s);
      end
   end endtask
   // Waits for phase 0, then runs one full instruction cycle
   task op(input [15:0] w, input [7:0] d); integer n; begin
      for (n = 0; n < 8 && phase_o !== 2'h0; n = n + 1) begin
         @(posedge clk_i);
         #1;
      end
      if (n == 8) begin
         mismatches = mismatches + 1;
         complete_run;
      end else begin
         instr_i = w;
         rd_data_i = d;
         repeat (4) begin
            @(posedge clk_i);
            #1;
         end
      end
   end endtask
   initial begin
      repeat (4) @(posedge clk_i);
      #1 rst_i = 1'b0;
      op(16'h2A10, 8'hFF);
      chk("addr", mem_addr_o, 12'h010);
      chk("wr", {mem_wr_o, wr_data_o}, 9'h100);
      chk("st", status_o, 5'h07);
      op(16'h2870, 8'h7F);
      chk("addr", mem_addr_o, 12'hF70);
      chk("wr", {mem_wr_o, wreg_o}, 9'h080);
      chk("st", status_o, 5'h1A);
      bank_sel = 4'h5;
      op(16'h2933, 8'h0F);
      chk("addr", {mem_addr_o, wreg_o, status_o}, 25'h0A66202);
      op(16'h2BFF, 8'h00);
      chk("top", {mem_addr_o, mem_wr_o, wr_data_o}, 21'h0B_FF01);
      ext = 1'b1;
      op(16'h2805, 8'h01);
      chk("addr", mem_addr_o, 12'h205);
      op(16'h2860, 8'h01);
      chk("addr", mem_addr_o, 12'hF60);
      ext = 1'b0;
      op(16'h2C10, 8'hFF);
      chk("other", {mem_wr_o, status_o, wreg_o}, 14'h0002);
      op(16'h4A10, 8'h05);
      chk("skip", {flush_o, busy_o, mem_wr_o, wr_data_o}, 11'h706);
      op(16'h2A10, 8'h00);
      chk("dropped", mem_wr_o, 1'b0);
      op(16'h4A10, 8'hFF);
      chk("noskip", flush_o, 1'b0);
      op(16'h3E10, 8'hFF);
      chk("zskip", flush_o, 1'b1);
      op(16'h0000, 8'h00);
      op(16'hEF34, 8'h00);
      chk("jmp1", pc_load_o, 1'b0);
      op(16'hFABC, 8'h00);
      chk("pc", pc_target_o, {20'hABC34, 1'b0});
      chk("jmp", {pc_load_o, flush_o, busy_o}, 3'h7);
      op(16'h2A10, 8'h00);
      chk("nop", mem_wr_o, 1'b0);
      complete_run;
   end
endmodule // increment_and_jump_execution_test
bind incr_jump_exec incr_jump_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .instr_i(instr_i), .rd_data_i(rd_data_i), .mem_addr_o(mem_addr_o),
   .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .wr_data_o(wr_data_o),
   .wreg_o(wreg_o), .status_o(status_o), .phase_o(phase_o),
   .pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .flush_o(flush_o));
